// File: src/smd_pkg.sv
/*
  Package for the safety monitor diagnostic responder: call codes, answer
  codes, colour codes, register map of the APB slave and carrier structs.
  Assumes a 32-bit APB master and a single 125 MHz clock.
*/
package smd_pkg;

  localparam int unsigned NUM_DEV  = 8;
  localparam int unsigned DEV_W    = 3;

  // Call codes on the bus
  localparam logic [3:0] CALL_STATE   = 4'hf;
  localparam logic [3:0] CALL_STORE   = 4'he;
  localparam logic [3:0] CALL_LED1    = 4'hd;
  localparam logic [3:0] CALL_LED2    = 4'hc;
  localparam logic [3:0] CALL_CNT1    = 4'hb;
  localparam logic [3:0] CALL_HI1     = 4'ha;
  localparam logic [3:0] CALL_LO1     = 4'h9;
  localparam logic [3:0] CALL_COL1    = 4'h8;
  localparam logic [3:0] CALL_CNT2    = 4'h7;
  localparam logic [3:0] CALL_HI2     = 4'h6;
  localparam logic [3:0] CALL_LO2     = 4'h5;
  localparam logic [3:0] CALL_COL2    = 4'h4;

  // User data codes D2..D0
  localparam logic [2:0] UD_OK        = 3'h0;
  localparam logic [2:0] UD_OFF1      = 3'h1;
  localparam logic [2:0] UD_OFF2      = 3'h2;
  localparam logic [2:0] UD_OFF_BOTH  = 3'h3;
  localparam logic [2:0] UD_CFG_PON   = 3'h4;
  localparam logic [2:0] UD_CFG       = 3'h5;
  localparam logic [2:0] UD_RESERVED  = 3'h6;
  localparam logic [2:0] UD_FATAL     = 3'h7;

  // Device colour codes
  localparam logic [2:0] COL_GREEN    = 3'h0;
  localparam logic [2:0] COL_GREEN_FL = 3'h1;
  localparam logic [2:0] COL_YEL      = 3'h2;
  localparam logic [2:0] COL_YEL_FL   = 3'h3;
  localparam logic [2:0] COL_RED      = 3'h4;
  localparam logic [2:0] COL_RED_FL   = 3'h5;
  localparam logic [2:0] COL_GREY     = 3'h6;

  localparam logic [2:0] CNT_MAX      = 3'h7;
  localparam int unsigned CNT_LIMIT   = 6;

  // Operating modes
  localparam logic [1:0] MODE_PROT    = 2'h0;
  localparam logic [1:0] MODE_PON     = 2'h1;
  localparam logic [1:0] MODE_CFG     = 2'h2;
  localparam logic [1:0] MODE_FATAL   = 2'h3;

  // Circuit topology
  localparam logic [1:0] TOPO_SINGLE  = 2'h0;
  localparam logic [1:0] TOPO_DEP     = 2'h1;
  localparam logic [1:0] TOPO_INDEP   = 2'h2;

  // Snapshot capture length in cycles, one per device plus one
  localparam logic [3:0] CAP_LAST     = 4'(NUM_DEV);

  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CALL    = 8'h04;
  localparam logic [7:0] ADDR_ANSWER  = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  // CTRL fields
  localparam int unsigned CTRL_SORT   = 0;
  localparam int unsigned CTRL_ACK    = 1;
  localparam int unsigned CTRL_TOPO   = 2;
  localparam int unsigned CTRL_C2CFG  = 4;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0011;

  typedef struct packed {
    logic [2:0]  colour;
    logic [1:0]  circuit;   // bit0 circuit 1, bit1 circuit 2
    logic [5:0]  index;
  } smd_dev_t;

  typedef struct packed {
    logic [1:0]  mode;
    logic        off1;
    logic        off2;
    logic [1:0]  led1;
    logic [1:0]  led2;
  } smd_mon_t;

endpackage : smd_pkg

// File: src/smd_responder.sv
/*
  Diagnostic responder of a safety monitor slave. Answers 4-bit data calls
  with 4-bit answers, detail and ready store calls from a captured snapshot, state calls from live state; configured over APB.
  Assumes the slave protocol layer delivers one call_valid pulse per call,
  and that monitor and device state inputs are synchronous to SYS_CLK_IN.
*/
// The APB interface to the registers and the placing of the registers are this design's own decisions.
// Functional notes
// (RULE1) Master alternates state and store calls
// (RULE2) Both calls carry identical three-bit user data
// (RULE3) D3 low for state, high for store
// (RULE4) Protective, no fault answers zero
// (RULE5) Circuit 2 OK when single, dependent, unconfigured
// (RULE6) State-to-store change captures a snapshot
// (RULE7) D3 stays low while capturing
// (RULE8) Detail calls answered from stored snapshot
// (RULE9) Setting selects sorted or unsorted detail
// (RULE10) No detail during configuration operation
// (RULE11) New state call discards snapshot
// (RULE12) Call codes 1111,1110,1101,1100 and onward
// (RULE13) Off codes 001, 010, 011
// (RULE14) Configuration codes 100, 101, fatal 111
// (RULE15) Store call D3 low means wait
// (RULE16) Master asks LEDs only after 10XX
// (RULE17) LED codes, D3 gives the circuit
// (RULE18) Seven colour codes green to grey
// (RULE19) Error lock released by ack or cycling
// (RULE20) Unassigned device always reports green
// (RULE21) Successive different calls differ in answers
// (RULE22) Count answer 0, 1..6, 7 for more
// (RULE23) Snapshot capture is atomic
`timescale 1ns/10ps
module smd_responder (
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 RST_N_IN,
  input  wire logic                 CALL_VALID_IN,
  input  wire logic [3:0]           CALL_CODE_IN,
  input  wire smd_pkg::smd_mon_t    MON_IN,
  input  wire smd_pkg::smd_dev_t [smd_pkg::NUM_DEV-1:0] DEV_IN,
  input  wire logic                 BUS_RESTART_IN,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  output logic                      ANSWER_VALID_OUT,
  output logic [3:0]                ANSWER_OUT,
  output logic                      ERROR_LOCK_OUT
);

  typedef enum logic [1:0] {SMD_IDLE, SMD_CAPTURE, SMD_READY} smd_state_t;

  smd_state_t                 state_reg,   state_next;
  logic [3:0]                 cap_reg,     cap_next;
  smd_pkg::smd_mon_t          mon_reg,     mon_next;
  smd_pkg::smd_dev_t [smd_pkg::NUM_DEV-1:0] snap_reg, snap_next;
  logic [3:0]                 last_call_reg, last_call_next;
  logic [3:0]                 answer_reg,  answer_next;
  logic                       aval_reg,    aval_next;
  logic [31:0]                ctrl_reg,    ctrl_next;
  logic [31:0]                prdata_reg,  prdata_next;
  logic                       lock_reg,    lock_next;
  logic [2:0]                 ptr_reg,     ptr_next;
  logic                       ptr_seen_reg, ptr_seen_next;

  // User data derived from live or captured monitor state, honouring topology
  function automatic logic [2:0] user_data(input smd_pkg::smd_mon_t m,
                                           input logic [31:0] c);
    logic off2;
    off2 = m.off2;
    if (c[smd_pkg::CTRL_TOPO +: 2] != smd_pkg::TOPO_INDEP ||
        !c[smd_pkg::CTRL_C2CFG])
      off2 = 1'b0;                                          // [RULE5]
    case (m.mode)
      smd_pkg::MODE_PROT:  user_data = {1'b0, off2, m.off1}; // [RULE4] [RULE13]
      smd_pkg::MODE_PON:   user_data = smd_pkg::UD_CFG_PON;  // [RULE14]
      smd_pkg::MODE_CFG:   user_data = smd_pkg::UD_CFG;      // [RULE14]
      default:             user_data = smd_pkg::UD_FATAL;    // [RULE14]
    endcase
  endfunction : user_data

  // Colour of a device, green when unassigned
  function automatic logic [2:0] dev_colour(input smd_pkg::smd_dev_t d);
    dev_colour = (d.circuit == 2'b00) ? smd_pkg::COL_GREEN : d.colour; // [RULE20] [RULE18]
  endfunction : dev_colour

  // Membership of a device in the current detail view
  function automatic logic in_view(input smd_pkg::smd_dev_t d, input logic sorted,
                                   input logic circ2);
    in_view = (dev_colour(d) != smd_pkg::COL_GREEN) &&
              (!sorted || (circ2 ? d.circuit[1] : d.circuit[0]));    // [RULE9]
  endfunction : in_view

  logic        sorted;
  logic        circ2_sel;
  logic [3:0]  n_view;
  logic [2:0]  cnt_code;
  logic [2:0]  first_idx;
  logic        cfg_mode;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;
  logic        lock_set;

  assign sorted    = ctrl_reg[smd_pkg::CTRL_SORT];
  assign cfg_mode  = (mon_reg.mode != smd_pkg::MODE_PROT);
  assign circ2_sel = (CALL_CODE_IN <= smd_pkg::CALL_CNT2);

  // Count and first matching device in the snapshot
  always_comb begin
    n_view    = 4'h0;
    first_idx = 3'h0;
    for (int i = smd_pkg::NUM_DEV - 1; i >= 0; i--) begin
      if (in_view(snap_reg[i], sorted, circ2_sel)) begin
        n_view    = n_view + 4'h1;
        first_idx = 3'(i);
      end
    end
    cnt_code = (n_view > 4'(smd_pkg::CNT_LIMIT)) ? smd_pkg::CNT_MAX : n_view[2:0]; // [RULE22]
  end

  assign addr_ok = (PADDR == smd_pkg::ADDR_CTRL) || (PADDR == smd_pkg::ADDR_CALL) ||
                   (PADDR == smd_pkg::ADDR_ANSWER) || (PADDR == smd_pkg::ADDR_STATUS);
  assign apb_wr  = PSEL && PENABLE && PWRITE;
  assign apb_rd  = PSEL && !PENABLE && !PWRITE;

  // Call handling and snapshot
  always_comb begin
    state_next     = state_reg;
    cap_next       = cap_reg;
    mon_next       = mon_reg;
    snap_next      = snap_reg;
    last_call_next = last_call_reg;
    answer_next    = answer_reg;
    aval_next      = 1'b0;
    ptr_next       = ptr_reg;
    ptr_seen_next  = ptr_seen_reg;
    case (state_reg)
      SMD_CAPTURE: begin
        // Whole set taken in one cycle at start, counter only delays D3
        if (cap_reg == smd_pkg::CAP_LAST) begin
          state_next = SMD_READY;                          // [RULE7]
        end else begin
          cap_next = cap_reg + 4'h1;
        end
      end
      default: begin
      end
    endcase
    if (CALL_VALID_IN) begin
      last_call_next = CALL_CODE_IN;
      aval_next      = 1'b1;
      case (CALL_CODE_IN)                                  // [RULE12]
        smd_pkg::CALL_STATE: begin
          state_next  = SMD_IDLE;                          // [RULE11]
          answer_next = {1'b0, user_data(MON_IN, ctrl_reg)}; // [RULE2] [RULE3] [RULE15]
        end
        smd_pkg::CALL_STORE: begin
          if (last_call_reg == smd_pkg::CALL_STATE) begin  // [RULE6]
            state_next = SMD_CAPTURE;
            cap_next   = 4'h0;
            mon_next   = MON_IN;                           // [RULE23]
            snap_next  = DEV_IN;                           // [RULE23]
            ptr_seen_next = 1'b0;
            answer_next = {1'b0, user_data(MON_IN, ctrl_reg)}; // [RULE7]
          end else if (state_reg == SMD_READY) begin
            answer_next = {1'b1, user_data(mon_reg, ctrl_reg)}; // [RULE3] [RULE8]
          end else begin
            answer_next = {1'b0, user_data(MON_IN, ctrl_reg)}; // [RULE7]
          end
        end
        default: begin
          if (state_reg != SMD_READY || cfg_mode) begin
            answer_next = {1'b1, smd_pkg::UD_RESERVED};     // [RULE10]
          end else begin
            case (CALL_CODE_IN)
              smd_pkg::CALL_LED1: answer_next = {2'b00, mon_reg.led1}; // [RULE17]
              smd_pkg::CALL_LED2: answer_next = {2'b10, mon_reg.led2}; // [RULE17]
              smd_pkg::CALL_CNT1, smd_pkg::CALL_CNT2: begin
                answer_next   = {1'b0, cnt_code};            // [RULE22]
                ptr_next      = first_idx;
                ptr_seen_next = 1'b1;
              end
              smd_pkg::CALL_HI1, smd_pkg::CALL_HI2:
                answer_next = {1'b1, snap_reg[ptr_reg].index[5:3]}; // [RULE8]
              smd_pkg::CALL_LO1, smd_pkg::CALL_LO2:
                answer_next = {1'b0, snap_reg[ptr_reg].index[2:0]}; // [RULE21]
              smd_pkg::CALL_COL1, smd_pkg::CALL_COL2:
                answer_next = {1'b1, dev_colour(snap_reg[ptr_reg])}; // [RULE18]
              default: answer_next = {1'b1, smd_pkg::UD_RESERVED};
            endcase
          end
        end
      endcase
    end
  end

  // Error lock release by ack or bus cycling; a set in the same cycle wins
  always_comb begin
    lock_set  = 1'b0;
    lock_next = lock_reg;
    for (int i = 0; i < smd_pkg::NUM_DEV; i++) begin
      if (DEV_IN[i].circuit != 2'b00 && DEV_IN[i].colour == smd_pkg::COL_RED_FL)
        lock_set = 1'b1;
    end
    if ((apb_wr && PADDR == smd_pkg::ADDR_CTRL && PWDATA[smd_pkg::CTRL_ACK]) ||
        BUS_RESTART_IN)
      lock_next = 1'b0;                                    // [RULE19]
    if (lock_set)
      lock_next = 1'b1;                                    // [RULE18]
  end

  // APB register file, zero wait states
  always_comb begin
    ctrl_next   = ctrl_reg;
    prdata_next = prdata_reg;
    if (apb_wr && PADDR == smd_pkg::ADDR_CTRL)
      ctrl_next = PWDATA & ~(32'h1 << smd_pkg::CTRL_ACK);
    if (apb_rd) begin
      case (PADDR)
        smd_pkg::ADDR_CTRL:   prdata_next = ctrl_reg;
        smd_pkg::ADDR_CALL:   prdata_next = {28'h0, last_call_reg};
        smd_pkg::ADDR_ANSWER: prdata_next = {28'h0, answer_reg};
        smd_pkg::ADDR_STATUS: prdata_next = {29'h0, lock_reg, 2'(state_reg)};
        default:              prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_reg     <= SMD_IDLE;
      cap_reg       <= 4'h0;
      mon_reg       <= '0;
      snap_reg      <= '0;
      last_call_reg <= 4'h0;
      answer_reg    <= 4'h0;
      aval_reg      <= 1'b0;
      ctrl_reg      <= smd_pkg::CTRL_RESET;
      prdata_reg    <= 32'h0;
      lock_reg      <= 1'b0;
      ptr_reg       <= 3'h0;
      ptr_seen_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cap_reg       <= cap_next;
      mon_reg       <= mon_next;
      snap_reg      <= snap_next;
      last_call_reg <= last_call_next;
      answer_reg    <= answer_next;
      aval_reg      <= aval_next;
      ctrl_reg      <= ctrl_next;
      prdata_reg    <= prdata_next;
      lock_reg      <= lock_next;
      ptr_reg       <= ptr_next;
      ptr_seen_reg  <= ptr_seen_next;
    end
  end

  assign PRDATA           = prdata_reg;
  assign PREADY           = 1'b1;
  assign PSLVERR          = PSEL && PENABLE && !addr_ok;
  assign ANSWER_VALID_OUT = aval_reg;
  assign ANSWER_OUT       = answer_reg;
  assign ERROR_LOCK_OUT   = lock_reg;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_state_d3_low: assert property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_STATE
    |=> !ANSWER_OUT[3] && ANSWER_VALID_OUT) else $error("state call D3 not low"); // [RULE3]
  a_store_d3_ready: assert property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_STORE
    && state_reg == SMD_READY && last_call_reg != smd_pkg::CALL_STATE
    |=> ANSWER_OUT[3]) else $error("store call D3 not high"); // [RULE3]
  a_capture_d3_low: assert property (state_reg == SMD_CAPTURE && CALL_VALID_IN
    && CALL_CODE_IN == smd_pkg::CALL_STORE |=> !ANSWER_OUT[3])
    else $error("D3 high while capturing"); // [RULE7]
  a_capture_len: assert property ($rose(state_reg == SMD_CAPTURE) && !CALL_VALID_IN
    ##1 !CALL_VALID_IN [*8] |=> state_reg == SMD_READY)
    else $error("capture length wrong"); // [RULE7]
  a_discard_snap: assert property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_STATE
    |=> state_reg == SMD_IDLE) else $error("snapshot kept"); // [RULE11]
  a_start_capture: assert property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_STORE
    && last_call_reg == smd_pkg::CALL_STATE |=> state_reg == SMD_CAPTURE
    && mon_reg == $past(MON_IN)) else $error("no capture on change"); // [RULE6]
  a_cfg_no_detail: assert property (CALL_VALID_IN && cfg_mode
    && CALL_CODE_IN < smd_pkg::CALL_STORE |=> ANSWER_OUT == {1'b1, smd_pkg::UD_RESERVED})
    else $error("detail in configuration"); // [RULE10]
  a_prot_ok_zero: assert property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_STATE
    && MON_IN.mode == smd_pkg::MODE_PROT && !MON_IN.off1 && !MON_IN.off2
    |=> ANSWER_OUT[2:0] == smd_pkg::UD_OK) else $error("OK not zero"); // [RULE4]
  a_count_sat: assert property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_CNT1
    && state_reg == SMD_READY && !cfg_mode && n_view > 4'(smd_pkg::CNT_LIMIT)
    |=> ANSWER_OUT == {1'b0, smd_pkg::CNT_MAX}) else $error("count not saturated"); // [RULE22]
  a_lock_release: assert property (BUS_RESTART_IN && !lock_set |=> !ERROR_LOCK_OUT)
    else $error("lock not released"); // [RULE19]

  c_full_cycle: cover property (state_reg == SMD_CAPTURE ##[1:20] state_reg == SMD_READY);
  c_led_call: cover property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_LED2
    && state_reg == SMD_READY);
  c_count_call: cover property (CALL_VALID_IN && CALL_CODE_IN == smd_pkg::CALL_CNT2
    && n_view != 4'h0 && state_reg == SMD_READY);

endmodule : smd_responder

// File: tb/smd_master_model.sv
/*
  Model of the network master that polls the diagnostic responder with calls.
  Assumes one clock shared with the responder and callers outside that order the calls.
*/
`timescale 1ns/10ps
module smd_master_model (
  input  wire logic       clk_in,
  input  wire logic       ans_valid_in,
  input  wire logic [3:0] answer_in,
  output logic            call_valid_out,
  output logic [3:0]      call_code_out
);
  initial begin
    call_valid_out = 1'b0;
    call_code_out  = 4'h5;
  end

  // Callers keep the polling order and gate detail calls
  task automatic send(input logic [3:0] code, output logic [3:0] ans, output logic ok);
    ok  = 1'b0;
    ans = 4'hx;
    @(posedge clk_in);
    call_valid_out <= 1'b1;
    call_code_out  <= code;
    @(posedge clk_in);
    call_valid_out <= 1'b0;
    // Idle code is scrambled so a stale code cannot pass for a call
    call_code_out  <= ~code;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_in);
      if (ans_valid_in === 1'b1) begin
        ok  = 1'b1;
        ans = answer_in;
      end
    end
  endtask : send
endmodule : smd_master_model

// File: tb/tb_top.sv
/*
  Self-checking bench: poll codes, snapshot detail calls, lock release, APB map.
  Assumes smd_pkg, smd_responder and smd_master_model are compiled before it.
*/
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, restart = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, call_valid, ans_valid, lock;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  call_code, answer;
  smd_pkg::smd_mon_t mon = '0;
  smd_pkg::smd_dev_t [smd_pkg::NUM_DEV-1:0] dev = '0, d;
  int          fails = 0, comparisons = 0;

  always #4 clk = ~clk;

  smd_responder dut_u (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CALL_VALID_IN(call_valid),
    .CALL_CODE_IN(call_code), .MON_IN(mon), .DEV_IN(dev), .BUS_RESTART_IN(restart),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ANSWER_VALID_OUT(ans_valid),
    .ANSWER_OUT(answer), .ERROR_LOCK_OUT(lock));

  smd_master_model mst_u (.clk_in(clk), .ans_valid_in(ans_valid), .answer_in(answer),
    .call_valid_out(call_valid), .call_code_out(call_code));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready", 32'(pready), 32'h1);
      conclude();
    end
  endtask : apb

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp,
                         input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
    check("pslverr", 32'(e), 32'(err_exp));
  endtask : reg_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, v, r, e);
  endtask : wr

  task automatic ask(input logic [3:0] code, input logic [3:0] exp, input string what);
    logic [3:0] a;
    logic       ok;
    mst_u.send(code, a, ok);
    check(what, 32'(a), 32'(exp));
    if (ok !== 1'b1)
      conclude();
  endtask : ask

  // Poll pair, then repeat the store call until the snapshot is ready
  task automatic snap(input smd_pkg::smd_mon_t m, input logic [2:0] ud);
    logic [3:0] a;
    logic       ok;
    int         n;
    mon <= m;
    ask(smd_pkg::CALL_STATE, {1'b0, ud}, "state answer");
    ask(smd_pkg::CALL_STORE, {1'b0, ud}, "store while capturing");
    n = 0;
    do begin
      mst_u.send(smd_pkg::CALL_STORE, a, ok);
      n++;
    end while (ok === 1'b1 && a[3] !== 1'b1 && n < 20);
    check("store ready", 32'(a), 32'({1'b1, ud}));
    if (a[3] !== 1'b1)
      conclude();
  endtask : snap

  task automatic wait_lock(input logic exp, input string what);
    int n;
    n = 0;
    while (lock !== exp && n < 8) begin
      @(posedge clk);
      n++;
    end
    check(what, 32'(lock), 32'(exp));
    if (lock !== exp)
      conclude();
  endtask : wait_lock

  task automatic t_reset;
    check("answer", 32'(answer), 32'h0);
    check("answer valid", 32'(ans_valid), 32'h0);
    reg_chk(smd_pkg::ADDR_CTRL, smd_pkg::CTRL_RESET, 1'b0, "ctrl reset");
    reg_chk(smd_pkg::ADDR_STATUS, 32'h0, 1'b0, "status reset");
    wr(8'h10, 32'hffff_ffff);
    reg_chk(8'h10, 32'h0, 1'b1, "unmapped");
    reg_chk(smd_pkg::ADDR_CTRL, smd_pkg::CTRL_RESET, 1'b0, "ctrl kept");
    $display("Test reset done");
  endtask : t_reset

  task automatic t_codes;
    logic [9:0] tab [10];
    smd_pkg::smd_mon_t m;
    // Fields: mode, off1, off2, topology, circuit 2 configured, user data
    tab = '{10'h028, 10'h0a9, 10'h06a, 10'h0eb, 10'h12c, 10'h22d, 10'h32f, 10'h0c9,
            10'h058, 10'h060};
    m = '0;
    for (int k = 0; k < 10; k++) begin
      wr(smd_pkg::ADDR_CTRL, {27'h0, tab[k][3], tab[k][5:4], 2'h1});
      m.mode = tab[k][9:8];
      m.off1 = tab[k][7];
      m.off2 = tab[k][6];
      snap(m, tab[k][2:0]);
    end
    $display("Test operating codes done");
  endtask : t_codes

  task automatic t_detail;
    logic [3:0] code [8];
    logic [3:0] exp [8];
    smd_pkg::smd_mon_t m;
    code = '{4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4};
    exp = '{4'h1, 4'hd, 4'h3, 4'ha, 4'h1, 4'h8, 4'h5, 4'hc};
    m = '{smd_pkg::MODE_PROT, 1'b1, 1'b1, 2'h2, 2'h3};
    for (int k = 0; k < smd_pkg::NUM_DEV; k++)
      d[k] = '{smd_pkg::COL_GREEN, 2'h1, 6'(8 + k)};
    wr(smd_pkg::ADDR_CTRL, 32'h19);
    dev <= d;
    snap(m, 3'h3);
    ask(smd_pkg::CALL_CNT1, 4'h0, "count none");
    d[0] = '{smd_pkg::COL_RED, 2'h2, 6'h05};
    d[1] = '{smd_pkg::COL_YEL, 2'h1, 6'h2b};
    d[3] = '{smd_pkg::COL_RED, 2'h0, 6'h01};
    dev <= d;
    snap(m, 3'h3);
    reg_chk(smd_pkg::ADDR_STATUS, 32'h2, 1'b0, "status ready");
    reg_chk(smd_pkg::ADDR_CALL, 32'he, 1'b0, "last call");
    reg_chk(smd_pkg::ADDR_ANSWER, 32'hb, 1'b0, "last answer");
    dev[0].colour <= smd_pkg::COL_GREEN;
    dev[1].colour <= smd_pkg::COL_GREEN;
    mon.led1 <= 2'h0;
    ask(smd_pkg::CALL_LED1, 4'h2, "led circuit 1");
    ask(smd_pkg::CALL_LED2, 4'hb, "led circuit 2");
    for (int k = 0; k < 8; k++)
      ask(code[k], exp[k], "sorted detail");
    ask(4'h0, 4'he, "reserved call");
    ask(smd_pkg::CALL_STATE, 4'h3, "state again");
    ask(smd_pkg::CALL_LED1, 4'he, "detail after discard");
    wr(smd_pkg::ADDR_CTRL, 32'h18);
    dev <= d;
    snap(m, 3'h3);
    ask(smd_pkg::CALL_CNT1, 4'h2, "unsorted count");
    for (int k = 1; k < 4; k++)
      ask(code[k], exp[k + 4], "unsorted detail");
    for (int k = 0; k < smd_pkg::NUM_DEV; k++)
      d[k].colour = smd_pkg::COL_RED;
    dev <= d;
    snap(m, 3'h3);
    ask(smd_pkg::CALL_CNT1, {1'b0, smd_pkg::CNT_MAX}, "count above six");
    $display("Test detail calls done");
  endtask : t_detail

  task automatic t_cfg;
    smd_pkg::smd_mon_t m;
    m = '0;
    m.mode = smd_pkg::MODE_CFG;
    snap(m, smd_pkg::UD_CFG);
    ask(smd_pkg::CALL_LED1, 4'he, "led in configuration");
    ask(smd_pkg::CALL_CNT1, 4'he, "count in configuration");
    $display("Test configuration refusal done");
  endtask : t_cfg

  task automatic t_lock;
    dev[2].colour <= smd_pkg::COL_RED_FL;
    wait_lock(1'b1, "lock set");
    dev[2].colour <= smd_pkg::COL_RED;
    repeat (4) @(posedge clk);
    check("lock held", 32'(lock), 32'h1);
    wr(smd_pkg::ADDR_CTRL, 32'h1a);
    wait_lock(1'b0, "lock after ack");
    dev[2].colour <= smd_pkg::COL_RED_FL;
    wait_lock(1'b1, "lock set again");
    dev[2].colour <= smd_pkg::COL_RED;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    wait_lock(1'b0, "lock after restart");
    dev[3].colour <= smd_pkg::COL_RED_FL;
    repeat (4) @(posedge clk);
    check("lock unassigned", 32'(lock), 32'h0);
    $display("Test error lock done");
  endtask : t_lock

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_detail();
    t_cfg();
    t_lock();
    conclude();
  end
endmodule : tb_top
